// ===== src/lpd_consts.vh
// address map, field positions, reset values and timing counts of the lcd panel driver
`ifndef LPD_CONSTS_VH
`define LPD_CONSTS_VH

// word index of each register, byte address is four times the index
`define LPD_IDX_CTRL      6'h00
`define LPD_IDX_PHASE     6'h01
`define LPD_IDX_SE_FIRST  6'h04
`define LPD_IDX_SE_LAST   6'h09
`define LPD_IDX_PIX_FIRST 6'h10
`define LPD_IDX_PIX_LAST  6'h27

// counts of registers and lines
`define LPD_SE_REGS    6
`define LPD_PIX_REGS   24
`define LPD_SEG_LINES  46
`define LPD_COM_LINES  4
`define LPD_UPPER_SEG  24
`define LPD_UPPER_REG  12
`define LPD_REGS_PER_COM 3

// panel_control fields
`define LPD_CTL_ON     7
`define LPD_CTL_SLPOFF 6
`define LPD_CTL_WFAIL  5
`define LPD_CTL_CS_HI  3
`define LPD_CTL_CS_LO  2
`define LPD_CTL_MUX_HI 1
`define LPD_CTL_MUX_LO 0

// phase_setup fields
`define LPD_PS_TYPEB   7
`define LPD_PS_BIAS    6
`define LPD_PS_ACTIVE  5
`define LPD_PS_WINDOW  4
`define LPD_PS_PRE_HI  3
`define LPD_PS_PRE_LO  0

// reset values
`define LPD_RST_MUX    2'h3
`define LPD_RST_CS     2'h0
`define LPD_RST_PRE    4'h0
`define LPD_RST_BYTE   8'h00

// clock source and common mux codes
`define LPD_CS_SYSDIV  2'h0
`define LPD_CS_TIMER1  2'h1
`define LPD_MUX_STATIC 2'h0

// system clock divided by 256
`define LPD_SYSDIV_LAST 8'hff

`endif

// ===== src/lpd_panel_ctrl.v
// register file, clock selection and common/segment sequencing of the lcd panel driver
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "lpd_consts.vh"
module lpd_panel_ctrl (
   // clock, reset, enable
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        clkEn,
   // avalon-mm slave
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // device context
   input  wire        sleepMode,
   input  wire        timer1Tick,
   input  wire        slowOscTick,
   // panel side
   output reg  [3:0]  comActive,
   output reg  [45:0] segLevel,
   output reg  [45:0] segPinLcd,
   output reg         drivePolarity,
   output reg         driverActive,
   output reg         staticBias,
   output reg         halfBias
);

   integer i;

   // panel_control
   reg        drvOn_q;
   reg        sleepOff_q;
   reg        wrFail_q;
   reg [1:0]  clkPick_q;
   reg [1:0]  comPick_q;
   // phase_setup
   reg        typeB_q;
   reg        biasPick_q;
   reg [3:0]  presc_q;
   // segment enables and pixel bits
   reg [7:0]  segEnMem [0:`LPD_SE_REGS-1];
   reg [7:0]  pixMem   [0:`LPD_PIX_REGS-1];
   // sequencer
   reg        running_q;
   reg [7:0]  sysDiv_q;
   reg [3:0]  prescCnt_q;
   reg [1:0]  comIdx_q;
   reg        halfPhase_q;
   reg        framePol_q;

   // bus decode
   wire [5:0] wordIdx  = avs_address[7:2];
   wire       busReq   = avs_read | avs_write;
   wire       busTake  = busReq & ~avs_waitrequest;
   wire       wrTake   = busTake & avs_write & avs_byteenable[0];
   wire       isCtrl   = (wordIdx == `LPD_IDX_CTRL);
   wire       isPhase  = (wordIdx == `LPD_IDX_PHASE);
   wire       isSe     = (wordIdx >= `LPD_IDX_SE_FIRST) && (wordIdx <= `LPD_IDX_SE_LAST);
   wire       isPix    = (wordIdx >= `LPD_IDX_PIX_FIRST) && (wordIdx <= `LPD_IDX_PIX_LAST);
   wire [5:0] seSel    = wordIdx - `LPD_IDX_SE_FIRST;
   wire [5:0] pixSel   = wordIdx - `LPD_IDX_PIX_FIRST;
   wire [7:0] wrByte   = avs_writedata[7:0];

   // pixel writes are refused only while a type-B frame of inverted polarity is on the glass
   wire       pixWindow = ~running_q | ~typeB_q | ~framePol_q;
   wire       pixWrite  = wrTake & isPix;
   wire       pixBlock  = pixWrite & ~pixWindow;

   // register views
   wire [7:0] ctrlView;
   wire [7:0] phaseView;
   assign ctrlView  = {drvOn_q, sleepOff_q, wrFail_q, 1'b0, clkPick_q, comPick_q};
   assign phaseView = {typeB_q, biasPick_q, running_q, pixWindow, presc_q};

   // read mux
   reg  [7:0] rdByte;
   always @* begin
      rdByte = `LPD_RST_BYTE;
      if (isCtrl) begin
         rdByte = ctrlView;
      end else if (isPhase) begin
         rdByte = phaseView;
      end else if (isSe) begin
         rdByte = segEnMem[seSel[2:0]];
      end else if (isPix) begin
         rdByte = pixMem[pixSel[4:0]];
      end
   end

   // bus handshake: waitrequest drops for one cycle, one cycle after the request rises
   always @(posedge core_clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if (clkEn) begin
         if (busReq && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h00_0000, rdByte};
         end else begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   // control and phase registers
   always @(posedge core_clk) begin
      if (!rst_n) begin
         drvOn_q    <= 1'b0;
         sleepOff_q <= 1'b0;
         wrFail_q   <= 1'b0;
         clkPick_q  <= `LPD_RST_CS;
         comPick_q  <= `LPD_RST_MUX;
         typeB_q    <= 1'b0;
         biasPick_q <= 1'b0;
         presc_q    <= `LPD_RST_PRE;
      end else if (clkEn) begin
         if (wrTake && isCtrl) begin
            drvOn_q    <= wrByte[`LPD_CTL_ON];
            sleepOff_q <= wrByte[`LPD_CTL_SLPOFF];
            clkPick_q  <= wrByte[`LPD_CTL_CS_HI:`LPD_CTL_CS_LO];
            comPick_q  <= wrByte[`LPD_CTL_MUX_HI:`LPD_CTL_MUX_LO];
         end
         if (wrTake && isPhase) begin
            typeB_q    <= wrByte[`LPD_PS_TYPEB];
            biasPick_q <= wrByte[`LPD_PS_BIAS];
            presc_q    <= wrByte[`LPD_PS_PRE_HI:`LPD_PS_PRE_LO];
         end
         // a refused pixel write sets the flag even in the cycle software clears it
         if (pixBlock) begin
            wrFail_q <= 1'b1;
         end else if (wrTake && isCtrl && !wrByte[`LPD_CTL_WFAIL]) begin
            wrFail_q <= 1'b0;
         end
      end
   end

   // segment enable and pixel storage
   always @(posedge core_clk) begin
      if (!rst_n) begin
         for (i = 0; i < `LPD_SE_REGS; i = i + 1) begin
            segEnMem[i] <= `LPD_RST_BYTE;
         end
         for (i = 0; i < `LPD_PIX_REGS; i = i + 1) begin
            pixMem[i] <= `LPD_RST_BYTE;
         end
      end else if (clkEn) begin
         if (wrTake && isSe) begin
            segEnMem[seSel[2:0]] <= wrByte;
         end
         // blocked writes leave the glass content untouched
         if (pixWrite && pixWindow) begin
            pixMem[pixSel[4:0]] <= wrByte;
         end
      end
   end

   // drive clock source and prescaler
   reg  srcTick;
   always @* begin
      if (clkPick_q == `LPD_CS_SYSDIV) begin
         srcTick = (sysDiv_q == `LPD_SYSDIV_LAST);
      end else if (clkPick_q == `LPD_CS_TIMER1) begin
         srcTick = timer1Tick;
      end else begin
         srcTick = slowOscTick;
      end
   end

   wire phaseTick = running_q & srcTick & (prescCnt_q == presc_q);
   wire lastCom   = (comIdx_q == comPick_q);
   // type-A finishes both polarities on a common before moving on
   wire comStep   = typeB_q | halfPhase_q;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         running_q   <= 1'b0;
         sysDiv_q    <= 8'h00;
         prescCnt_q  <= 4'h0;
         comIdx_q    <= 2'h0;
         halfPhase_q <= 1'b0;
         framePol_q  <= 1'b0;
      end else if (clkEn) begin
         running_q <= drvOn_q & ~(sleepMode & sleepOff_q);
         sysDiv_q  <= sysDiv_q + 8'h01;
         if (!running_q) begin
            prescCnt_q  <= 4'h0;
            comIdx_q    <= 2'h0;
            halfPhase_q <= 1'b0;
            framePol_q  <= 1'b0;
         end else if (srcTick) begin
            if (prescCnt_q == presc_q) begin
               prescCnt_q <= 4'h0;
            end else begin
               prescCnt_q <= prescCnt_q + 4'h1;
            end
         end
         if (phaseTick) begin
            halfPhase_q <= ~halfPhase_q;
            if (!typeB_q) begin
               framePol_q <= ~framePol_q;
            end
            if (comStep) begin
               // commons cycle through comPick+1 lines
               if (lastCom) begin
                  comIdx_q <= 2'h0;
                  if (typeB_q) begin
                     framePol_q <= ~framePol_q;
                  end
               end else begin
                  comIdx_q <= comIdx_q + 2'h1;
               end
               halfPhase_q <= 1'b0;
            end
         end
      end
   end

   // per-segment pixel selection for the common being driven
   wire [45:0] segNext;
   wire [45:0] segEnFlat;
   genvar s;
   generate
      for (s = 0; s < `LPD_SEG_LINES; s = s + 1) begin : gSeg
         localparam integer UP   = (s >= `LPD_UPPER_SEG) ? 1 : 0;
         localparam integer REL  = s - UP * `LPD_UPPER_SEG;
         localparam integer BASE = UP * `LPD_UPPER_REG + REL / 8;
         wire [4:0] regIdx = BASE[4:0] + {1'b0, comIdx_q, 2'b00} - {3'b000, comIdx_q};
         wire       pixBit = pixMem[regIdx][REL % 8];
         assign segEnFlat[s] = segEnMem[s / 8][s % 8];
         assign segNext[s]   = pixBit & segEnFlat[s];
      end
   endgenerate

   // one-hot common select
   reg [3:0] comNext;
   always @* begin
      comNext = 4'h0;
      if (running_q) begin
         case (comIdx_q)
            2'h0:    comNext = 4'h1;
            2'h1:    comNext = 4'h2;
            2'h2:    comNext = 4'h4;
            2'h3:    comNext = 4'h8;
            default: comNext = 4'h0;
         endcase
      end
   end

   // panel outputs, all registered
   always @(posedge core_clk) begin
      if (!rst_n) begin
         comActive     <= 4'h0;
         segLevel      <= 46'h0000_0000_0000;
         segPinLcd     <= 46'h0000_0000_0000;
         drivePolarity <= 1'b0;
         driverActive  <= 1'b0;
         staticBias    <= 1'b0;
         halfBias      <= 1'b0;
      end else if (clkEn) begin
         comActive     <= comNext;
         // a stopped driver leaves every segment clear
         segLevel      <= running_q ? segNext : 46'h0000_0000_0000;
         segPinLcd     <= segEnFlat;
         drivePolarity <= running_q & framePol_q;
         driverActive  <= running_q;
         staticBias    <= (comPick_q == `LPD_MUX_STATIC);
         // half bias only has meaning with two or three commons
         halfBias      <= biasPick_q & (comPick_q != `LPD_MUX_STATIC)
                          & (comPick_q != `LPD_RST_MUX);
      end
   end

endmodule

// ===== sim/lpd_panel_props.sv
// port checks of the lcd panel driver
`timescale 1ns/1ps
module lpd_panel_props (
   // clock, reset, enable
   input wire        core_clk,
   input wire        rst_n,
   input wire        clkEn,
   // avalon-mm slave
   input wire [7:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   // device context
   input wire        sleepMode,
   input wire        timer1Tick,
   input wire        slowOscTick,
   // panel side
   input wire [3:0]  comActive,
   input wire [45:0] segLevel,
   input wire [45:0] segPinLcd,
   input wire        drivePolarity,
   input wire        driverActive,
   input wire        staticBias,
   input wire        halfBias
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_raise;
      clkEn && avs_waitrequest && $rose(avs_read || avs_write);
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_answer: assert property (s_raise |=> s_answer) else $error("bus answer late or too long");
   a_lane_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper lanes set");
   a_reset_quiet: assert property ($rose(rst_n) |-> avs_waitrequest && comActive == 4'h0 && !driverActive)
      else $error("outputs not quiet after reset");
   a_stop_idle: assert property (!driverActive |-> comActive == 4'h0 && segLevel == 46'h0)
      else $error("panel driven while stopped");
   a_one_common: assert property ($onehot0(comActive)) else $error("more than one common driven");
   a_pin_gate: assert property ((segLevel & ~segPinLcd) == 46'h0) else $error("segment on disabled pin");
   a_static_com: assert property (staticBias && driverActive |-> comActive[3:1] == 3'h0)
      else $error("static drive left common 0");
   a_bias_excl: assert property (!(staticBias && halfBias)) else $error("half bias in static mode");
endmodule
bind lpd_panel_ctrl lpd_panel_props u_props (.*);

// ===== sim/lpd_glass_model.sv
// segment glass: holds the last pixel row shown on each common
`timescale 1ns/1ps
module lpd_glass_model (
   // panel pins
   input wire         core_clk,
   input wire [3:0]   comActive,
   input wire [45:0]  segLevel,
   // what the glass shows, 46 bits per common
   output reg [183:0] darkRows
);
   integer c;
   initial darkRows = 184'h0;
   always @(posedge core_clk) begin
      for (c = 0; c < 4; c = c + 1) begin
         if (comActive[c]) begin
            darkRows[c * 46 +: 46] <= segLevel;
         end
      end
   end
endmodule

// ===== sim/lpd_panel_ctrl_bench.sv
// self-checking bench of the lcd panel driver
`timescale 1ns/1ps
module lpd_panel_ctrl_bench;
   reg          core_clk, rst_n, clkEn, avs_read, avs_write, sleepMode, timer1Tick, slowOscTick;
   reg  [7:0]   avs_address;
   reg  [31:0]  avs_writedata, rng, rd;
   reg  [3:0]   avs_byteenable;
   wire [31:0]  avs_readdata;
   wire         avs_waitrequest, drivePolarity, driverActive, staticBias, halfBias;
   wire [3:0]   comActive;
   wire [45:0]  segLevel, segPinLcd;
   wire [183:0] darkRows;
   integer      n_fail, checked, i, moves;
   reg  [7:0]   mdl [0:63];
   wire [45:0]  seExp = {mdl[9][5:0], mdl[8], mdl[7], mdl[6], mdl[5], mdl[4]};
   lpd_panel_ctrl DUT (.*);
   lpd_glass_model glass (.core_clk(core_clk), .comActive(comActive), .segLevel(segLevel), .darkRows(darkRows));
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   function [45:0] expRow(input integer cc);
      expRow = seExp & {mdl[30 + 3 * cc][5:0], mdl[29 + 3 * cc], mdl[28 + 3 * cc],
                        mdl[18 + 3 * cc], mdl[17 + 3 * cc], mdl[16 + 3 * cc]};
   endfunction
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input [63:0] seen, input [63:0] exp, input [63:0] what);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // waits on waitrequest for at most 20 polls, then fails the test
   task bus(input wr, input [7:0] a, input [7:0] d);
      integer t;
      begin
         @(posedge core_clk);
         avs_address <= a;
         avs_writedata <= {24'h0, d};
         avs_write <= wr;
         avs_read <= !wr;
         t = 0;
         @(posedge core_clk);
         while (avs_waitrequest !== 1'b0 && t < 20) begin
            t = t + 1;
            @(posedge core_clk);
         end
         rd = avs_readdata;
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         if (t == 20) begin
            n_fail = n_fail + 1;
            end_of_test;
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         bus(1'b1, a, d);
         mdl[a[7:2]] = d;
      end
   endtask
   task rdc(input [7:0] a, input [7:0] e);
      begin
         bus(1'b0, a, 8'h00);
         chk(rd, {24'h0, e}, "reg");
      end
   endtask
   // src 1 pulses timer1Tick, 2 slowOscTick, 0 neither; counts common changes
   task run(input integer n, input integer src);
      integer k;
      reg [3:0] last;
      begin
         moves = 0;
         last = comActive;
         for (k = 0; k < n; k = k + 1) begin
            @(posedge core_clk);
            rng = xs(rng);
            timer1Tick <= (src == 1) && rng[0];
            slowOscTick <= (src == 2) && rng[0];
            if (comActive !== last) moves = moves + 1;
            last = comActive;
         end
         @(posedge core_clk);
         timer1Tick <= 1'b0;
         slowOscTick <= 1'b0;
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      repeat (30000) @(posedge core_clk);
      n_fail = n_fail + 1;
      end_of_test;
   end
   initial begin
      {rst_n, avs_read, avs_write, sleepMode, timer1Tick, slowOscTick} = 6'h0;
      {avs_address, avs_writedata, rd} = 72'h0;
      clkEn = 1'b1;
      avs_byteenable = 4'h1;
      n_fail = 0;
      checked = 0;
      rng = 32'h0000_3a28;
      for (i = 0; i < 64; i = i + 1) mdl[i] = 8'h00;
      mdl[0] = 8'h03;
      mdl[1] = 8'h10;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      for (i = 4; i < 40; i = i + 1) begin
         rng = xs(rng);
         if (i == 9 || (i >= 28 && (i - 28) % 3 == 2)) rng[7:6] = 2'b00;
         if (i < 10 || i > 15) wr({i[5:0], 2'b00}, rng[7:0]);
      end
      for (i = 0; i < 64; i = i + 1) rdc({i[5:0], 2'b00}, mdl[i]);
      chk(segPinLcd, seExp, "pins");
      bus(1'b1, 8'ha0, 8'h5a);
      rdc(8'ha0, 8'h00);
      avs_byteenable <= 4'h0;
      bus(1'b1, 8'h40, ~mdl[16]);
      avs_byteenable <= 4'h1;
      rdc(8'h40, mdl[16]);
      wr(8'h04, 8'h00);
      wr(8'h00, 8'h87);
      // type-A with four commons needs eight phase ticks of timer1Tick to visit every common
      run(2400, 1);
      for (i = 0; i < 4; i = i + 1) chk(darkRows[i * 46 +: 46], expRow(i), "row");
      for (i = 0; i < 4; i = i + 1) begin
         wr(8'h00, {4'h8, i[1:0], 2'b11});
         run(700, i == 0 ? 0 : (i == 1 ? 1 : 2));
         chk(moves > 0, 1, "tick");
         if (i > 0) run(100, i == 1 ? 2 : 1);
         if (i > 0) chk(moves, 0, "wrongsrc");
      end
      wr(8'h00, 8'h87);
      sleepMode <= 1'b1;
      run(10, 1);
      chk(driverActive, 1, "sleepon");
      wr(8'h00, 8'hc7);
      run(5, 1);
      chk(driverActive, 0, "sleepoff");
      sleepMode <= 1'b0;
      run(5, 1);
      chk(driverActive, 1, "wake");
      wr(8'h00, 8'h07);
      run(5, 1);
      chk(driverActive, 0, "off");
      chk(drivePolarity, 0, "pol");
      wr(8'h04, 8'h80);
      wr(8'h00, 8'h87);
      rd = 0;
      for (i = 0; i < 40 && rd[5] !== 1'b1; i = i + 1) begin
         // a type-B frame of four commons lasts four timer1Tick phase ticks, so keep stepping until a write lands in the inverted one
         run(100, 1);
         bus(1'b1, 8'h9c, 8'hff);
         bus(1'b0, 8'h00, 8'h00);
      end
      chk(rd[5], 1, "pixel_write_fail_flag");
      bus(1'b1, 8'h00, 8'ha7);
      rdc(8'h00, 8'ha7);
      bus(1'b1, 8'h00, 8'h87);
      rdc(8'h00, 8'h87);
      wr(8'h00, 8'h01);
      wr(8'h04, 8'h40);
      run(3, 0);
      chk({halfBias, staticBias}, 2'b10, "bias");
      wr(8'h04, 8'h00);
      wr(8'h00, 8'h84);
      run(100, 1);
      chk({halfBias, staticBias}, 2'b01, "static");
      chk(darkRows[45:0], expRow(0), "row0");
      end_of_test;
   end
endmodule
